// ### common/pxr_pkg.sv
`default_nettype none
package pxr_pkg;

  // device addressing
  localparam logic [6:0] TARGET_ADDR_RESET = 7'h29;

  // 16-bit register indices
  localparam logic [15:0] IDX_INT_CLEAR = 16'h0015;
  localparam logic [15:0] IDX_POWERUP = 16'h0016;
  localparam logic [15:0] IDX_RANGE_START = 16'h0018;
  localparam logic [15:0] IDX_RANGE_STATUS = 16'h004D;
  localparam logic [15:0] IDX_INT_STATUS = 16'h004F;
  localparam logic [15:0] IDX_RANGE_VALUE = 16'h0062;
  localparam logic [15:0] IDX_MEAS_PERIOD = 16'h00A0;
  localparam logic [15:0] IDX_TARGET_ADDR = 16'h0212;

  // reset values and command codes
  localparam logic [7:0] POWERUP_RESET = 8'h01;
  localparam logic [7:0] MEAS_PERIOD_RESET = 8'h0A;
  localparam logic [7:0] START_SINGLE = 8'h01;
  localparam logic [7:0] START_CONT = 8'h03;

  // field positions
  localparam int STATUS_READY_BIT = 0;
  localparam int INT_NEW_SAMPLE_BIT = 2;
  localparam int CLEAR_RANGE_BIT = 0;

  // cycle counts at 250 MHz (10 us each)
  localparam int MEAS_CYCLES = 2500;
  localparam int PERIOD_UNIT_CYCLES = 2500;
  localparam int TIMER_W = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // one result from the ranging front end
  typedef struct packed {
    logic [3:0] error_code;
    logic [7:0] distance_mm;
  } pxr_sample_t;

  typedef enum {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ACK,
    LINK_RX,
    LINK_TX,
    LINK_TX_ACK
  } pxr_link_state_t;

  typedef enum {
    RNG_IDLE,
    RNG_MEASURE,
    RNG_WAIT
  } pxr_range_state_t;

endpackage
`default_nettype wire

// ### core/pxr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pxr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second one
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule
`default_nettype wire

// ### core/pxr_range_engine.sv
`timescale 1ns/100ps
`default_nettype none
module pxr_range_engine
  import pxr_pkg::*;
#(
  parameter int MEAS_LEN = pxr_pkg::MEAS_CYCLES,
  parameter int UNIT_LEN = pxr_pkg::PERIOD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // commands
  input wire logic i_abort,
  input wire logic i_cmd_single,
  input wire logic i_cmd_cont,
  input wire logic [7:0] i_period,
  // front end result
  input wire pxr_pkg::pxr_sample_t i_sample,
  // status
  output logic o_idle,
  output logic o_continuous,
  output logic o_measuring,
  output logic o_done,
  output pxr_pkg::pxr_sample_t o_result
);

  pxr_range_state_t state;
  logic [TIMER_W-1:0] timer;
  logic [7:0] units_left;
  logic stop_now;

  assign stop_now = i_cmd_single && o_continuous;
  assign o_idle = (state == RNG_IDLE);
  assign o_measuring = (state == RNG_MEASURE);

  // sequencing of measurements and the gap between them
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= RNG_IDLE;
      timer <= '0;
      units_left <= 8'h00;
    end else if (i_abort) begin
      state <= RNG_IDLE;
    end else begin
      case (state)
        RNG_IDLE: begin
          if (i_cmd_single || i_cmd_cont) begin
            state <= RNG_MEASURE; // [RULE9] [RULE10]
            timer <= TIMER_W'(MEAS_LEN - 1);
          end
        end
        RNG_MEASURE: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (o_continuous && !stop_now) begin
            state <= RNG_WAIT; // [RULE10]
            timer <= TIMER_W'(UNIT_LEN - 1);
            units_left <= i_period;
          end else begin
            state <= RNG_IDLE; // software standby [RULE9]
          end
        end
        RNG_WAIT: begin
          if (stop_now) begin
            state <= RNG_IDLE; // [RULE11]
          end else if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (units_left == 8'h00) begin
            state <= RNG_MEASURE; // [RULE10]
            timer <= TIMER_W'(MEAS_LEN - 1);
          end else begin
            units_left <= units_left - 8'h01;
            timer <= TIMER_W'(UNIT_LEN - 1);
          end
        end
        default: state <= RNG_IDLE;
      endcase
    end
  end

  // repeat mode; a single-shot code while repeating is the stop
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_continuous <= 1'b0;
    end else if (i_abort || stop_now) begin
      o_continuous <= 1'b0; // [RULE11]
    end else if (o_idle && i_cmd_cont) begin
      o_continuous <= 1'b1; // [RULE10]
    end
  end

  // result capture at the end of each measurement
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
      o_result <= '0;
    end else begin
      o_done <= o_measuring && (timer == '0) && !i_abort;
      if (o_measuring && (timer == '0)) begin
        o_result <= i_sample; // [RULE14] [RULE17]
      end
    end
  end

endmodule
`default_nettype wire

// ### core/pxr_proximity_ranging_control.sv
// Summary of operation
// RULE1 - answer at target address 0x29 after reset
// RULE2 - take new address written at index 0x212
// RULE3 - two index bytes precede every data byte
// RULE4 - power-up indication reads 0x01 when fresh
// RULE5 - hold value host writes to power-up indication
// RULE6 - power-up indication back to 0x01 on shutdown
// RULE7 - pin zero low shuts the device down
// RULE8 - host reloads settings before ranging after shutdown
// RULE9 - code 0x01 runs one measurement, then standby
// RULE10 - code 0x03 repeats measurements at set period
// RULE11 - code 0x01 while repeating stops the repeats
// RULE12 - status bit 0 set when start accepted; the code sets it while the engine is idle and clears it while ranging
// RULE13 - completion sets interrupt status bit 2
// RULE14 - distance in millimetres lands in range value
// RULE15 - clear write of 0x07 drops pending flags
// RULE16 - new sample flag sticks until host clears
// RULE17 - error code sits in status bits 7:4
`timescale 1ns/100ps
`default_nettype none
module pxr_proximity_ranging_control #(
  parameter int MEAS_LEN = pxr_pkg::MEAS_CYCLES,
  parameter int UNIT_LEN = pxr_pkg::PERIOD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // two-wire serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // general-purpose pin zero, shutdown when low
  input wire logic i_gpio0_shutdown_n,
  // ranging front end
  input wire pxr_pkg::pxr_sample_t i_sensor_sample,
  output logic o_ranging_active
);
  import pxr_pkg::*;

  logic [2:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic run_s;
  logic scl_q;
  logic sda_q;
  logic shutdown;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  pxr_link_state_t link_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic rw_read;
  logic master_nack;
  logic [1:0] byte_phase;
  logic [15:0] reg_index;
  logic byte_in;
  logic [7:0] rd_byte;

  logic wr_stb;
  logic [7:0] wr_data;
  logic [6:0] target_addr;
  logic [7:0] powerup_ind;
  logic [7:0] meas_period;
  logic int_new_sample;
  logic cmd_single;
  logic cmd_cont;

  logic eng_idle;
  logic eng_cont;
  logic eng_done;
  pxr_sample_t eng_result;

  // register read decode, used for every byte sent back
  function automatic logic [7:0] read_reg(input logic [15:0] idx);
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      IDX_POWERUP: val = powerup_ind; // [RULE4]
      IDX_RANGE_START: val = {6'h00, eng_cont, !eng_idle};
      IDX_RANGE_STATUS: begin
        val = {eng_result.error_code, 4'h0}; // [RULE17]
        val[STATUS_READY_BIT] = eng_idle; // [RULE12]
      end
      IDX_INT_STATUS: val[INT_NEW_SAMPLE_BIT] = int_new_sample;
      IDX_RANGE_VALUE: val = eng_result.distance_mm; // [RULE14]
      IDX_MEAS_PERIOD: val = meas_period;
      IDX_TARGET_ADDR: val = {1'b0, target_addr};
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // bus pins and the shutdown pin come from outside the clock domain
  pxr_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async({i_scl, i_sda, i_gpio0_shutdown_n}),
    .o_sync(pin_sync)
  );

  assign {scl_s, sda_s, run_s} = pin_sync;

  // previous synchronised levels for edge and condition detection
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // low level on pin zero holds the whole device in shutdown
  assign shutdown = !run_s; // [RULE7]
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign bus_start = scl_s && scl_q && sda_q && !sda_s;
  assign bus_stop = scl_s && scl_q && !sda_q && sda_s;
  assign byte_in = scl_fall && (bit_cnt == BITS_PER_BYTE);

  // a process, not an assign, so it also follows the registers it reads
  always_comb begin
    rd_byte = read_reg(reg_index);
  end

  // serial protocol engine; sda changes only after scl has fallen
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_state <= LINK_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      rw_read <= 1'b0;
      master_nack <= 1'b0;
      byte_phase <= 2'h0;
      reg_index <= 16'h0000;
      o_sda_oe <= 1'b0;
    end else if (shutdown || bus_stop) begin
      link_state <= LINK_IDLE;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the index so a read follows a write
      link_state <= LINK_ADDR;
      bit_cnt <= 4'h0;
      byte_phase <= 2'h0;
      o_sda_oe <= 1'b0;
    end else begin
      case (link_state)
        LINK_ADDR: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_in) begin
            if (rx_shift[7:1] == target_addr) begin
              link_state <= LINK_ACK; // [RULE1] [RULE2]
              rw_read <= rx_shift[0];
              o_sda_oe <= 1'b1;
            end else begin
              link_state <= LINK_IDLE;
            end
          end
        end
        LINK_RX: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_in) begin
            link_state <= LINK_ACK;
            o_sda_oe <= 1'b1;
            // index high byte, then low byte, then data
            case (byte_phase)
              2'h0: reg_index[15:8] <= rx_shift; // [RULE3]
              2'h1: reg_index[7:0] <= rx_shift; // [RULE3]
              default: reg_index <= reg_index + 16'h0001;
            endcase
            if (byte_phase != 2'h2) begin
              byte_phase <= byte_phase + 2'h1;
            end
          end
        end
        LINK_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              link_state <= LINK_TX;
              tx_shift <= rd_byte;
              o_sda_oe <= !rd_byte[7];
              reg_index <= reg_index + 16'h0001;
            end else begin
              link_state <= LINK_RX;
              o_sda_oe <= 1'b0;
            end
          end
        end
        LINK_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_in) begin
            link_state <= LINK_TX_ACK;
            o_sda_oe <= 1'b0;
          end else if (scl_fall) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            o_sda_oe <= !tx_shift[6];
          end
        end
        LINK_TX_ACK: begin
          if (scl_rise) begin
            master_nack <= sda_s;
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              link_state <= LINK_IDLE;
            end else begin
              link_state <= LINK_TX;
              tx_shift <= rd_byte;
              o_sda_oe <= !rd_byte[7];
              reg_index <= reg_index + 16'h0001;
            end
          end
        end
        default: link_state <= LINK_IDLE;
      endcase
    end
  end

  // the line is open drain: only a low level is ever driven
  assign o_sda = 1'b0;

  // a data byte is written at the moment it is acknowledged
  assign wr_stb = (link_state == LINK_RX) && byte_in && !shutdown &&
                  (byte_phase == 2'h2); // [RULE3]
  assign wr_data = rx_shift;
  assign cmd_single = wr_stb && (reg_index == IDX_RANGE_START) &&
                      (wr_data == START_SINGLE); // [RULE9] [RULE11]
  assign cmd_cont = wr_stb && (reg_index == IDX_RANGE_START) &&
                    (wr_data == START_CONT); // [RULE10]

  // own target address; a new one takes effect from the next address
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      target_addr <= TARGET_ADDR_RESET; // [RULE1]
    end else if (shutdown) begin
      target_addr <= TARGET_ADDR_RESET; // [RULE1]
    end else if (wr_stb && (reg_index == IDX_TARGET_ADDR)) begin
      target_addr <= wr_data[6:0]; // [RULE2]
    end
  end

  // fresh-out-of-power-up marker
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      powerup_ind <= POWERUP_RESET; // [RULE4]
    end else if (shutdown) begin
      powerup_ind <= POWERUP_RESET; // [RULE6]
    end else if (wr_stb && (reg_index == IDX_POWERUP)) begin
      powerup_ind <= wr_data; // [RULE5]
    end
  end

  // gap between repeated measurements, in units of the period tick
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meas_period <= MEAS_PERIOD_RESET;
    end else if (shutdown) begin
      meas_period <= MEAS_PERIOD_RESET;
    end else if (wr_stb && (reg_index == IDX_MEAS_PERIOD)) begin
      meas_period <= wr_data;
    end
  end

  // sticky new-sample flag; a completion in the clear cycle wins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_new_sample <= 1'b0;
    end else if (shutdown) begin
      int_new_sample <= 1'b0;
    end else if (eng_done) begin
      int_new_sample <= 1'b1; // [RULE13] [RULE16]
    end else if (wr_stb && (reg_index == IDX_INT_CLEAR) &&
                 wr_data[CLEAR_RANGE_BIT]) begin
      int_new_sample <= 1'b0; // [RULE15]
    end
  end

  // measurement sequencer; shutdown drops any ranging in progress
  pxr_range_engine #(
    .MEAS_LEN(MEAS_LEN),
    .UNIT_LEN(UNIT_LEN)
  ) u_range_engine (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_abort(shutdown),
    .i_cmd_single(cmd_single),
    .i_cmd_cont(cmd_cont),
    .i_period(meas_period),
    .i_sample(i_sensor_sample),
    .o_idle(eng_idle),
    .o_continuous(eng_cont),
    .o_measuring(o_ranging_active),
    .o_done(eng_done),
    .o_result(eng_result)
  );

endmodule
`default_nettype wire

// ### dv/pxr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// two-wire bus master standing in for the host; lines idle released high
module pxr_host_model (
  // clock
  input wire logic i_clock,
  // resolved data wire
  input wire logic i_sda,
  // master drive, 1 = released to the pull-up
  output logic o_scl,
  output logic o_sda
);
  // 10 clocks per phase keeps both phases above the 8-clock minimum
  localparam int HALF = 10;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // data moves mid-low so it never changes near an scl edge
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    o_sda <= b;
    tick(HALF / 2);
    o_scl <= 1'b1;
    tick(HALF / 2);
    r = i_sda;
    tick(HALF / 2);
    o_scl <= 1'b0;
  endtask

  // also serves as repeated start from scl low
  task automatic start();
    o_sda <= 1'b1;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda <= 1'b0;
    tick(HALF);
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    tick(HALF / 2);
    o_sda <= 1'b0;
    tick(HALF / 2);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda <= 1'b1;
    tick(HALF);
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // index sent high byte first ahead of any data
  task automatic index(input logic [6:0] a, input logic [15:0] idx,
                       output logic ack);
    logic k0, k1, k2;
    start();
    wbyte({a, 1'b0}, k0);
    wbyte(idx[15:8], k1);
    wbyte(idx[7:0], k2);
    ack = k0 & k1 & k2;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] idx,
                    input logic [7:0] v, output logic ack);
    logic k0, k1;
    index(a, idx, k0);
    wbyte(v, k1);
    stop();
    ack = k0 & k1;
  endtask

  // single byte read ends with a master nack
  task automatic rd(input logic [6:0] a, input logic [15:0] idx,
                    output logic [7:0] v, output logic ack);
    logic k0, k1, r;
    index(a, idx, k0);
    start();
    wbyte({a, 1'b1}, k1);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(1'b1, r);
    stop();
    ack = k0 & k1;
  endtask
endmodule
`default_nettype wire

// ### dv/pxr_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module pxr_ctrl_props #(
  parameter int MEAS_LEN = 2500,
  parameter int UNIT_LEN = 2500
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // pins
  input wire logic i_scl,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_gpio0_shutdown_n,
  input wire logic o_ranging_active
);
  int run_cnt;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // cycles spent in the current measurement, zero when idle
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n)
      run_cnt <= 0;
    else if (o_ranging_active)
      run_cnt <= run_cnt + 1;
    else
      run_cnt <= 0;
  end

  sda_open_drain_a: assert property (o_sda_oe |-> !o_sda)
    else $error("sda driven high");
  oe_scl_low_a: assert property (
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("sda drive moved outside scl low");
  scl_high_quiet_a: assert property (i_scl [*4] |-> $stable(o_sda_oe))
    else $error("sda drive moved while scl high");
  ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("sda drive too short");
  meas_length_a: assert property (
    $fell(o_ranging_active) |-> run_cnt == MEAS_LEN)
    else $error("measurement length wrong");
  meas_gap_a: assert property (
    $fell(o_ranging_active) |-> !o_ranging_active [*8])
    else $error("repeat started too soon");
  shutdown_idle_a: assert property (
    !i_gpio0_shutdown_n [*5] |-> !o_ranging_active && !o_sda_oe)
    else $error("active during shutdown");
  reset_quiet_a: assert property (disable iff (1'b0)
    !i_reset_n |-> !o_sda_oe && !o_ranging_active)
    else $error("outputs active in reset");
endmodule

bind pxr_proximity_ranging_control pxr_ctrl_props #(
  .MEAS_LEN(MEAS_LEN),
  .UNIT_LEN(UNIT_LEN)
) u_props (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_scl(i_scl),
  .o_sda(o_sda),
  .o_sda_oe(o_sda_oe),
  .i_gpio0_shutdown_n(i_gpio0_shutdown_n),
  .o_ranging_active(o_ranging_active)
);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pxr_pkg::*;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] mask;
    logic [7:0] exp;
  } pxr_row_t;
  localparam int LIMIT = 60000;
  localparam logic [6:0] A0 = TARGET_ADDR_RESET;
  logic i_clock;
  logic i_reset_n;
  logic scl;
  logic m_sda;
  logic sda;
  logic o_sda;
  logic o_sda_oe;
  logic pin_n;
  logic active;
  logic last_act;
  logic ack;
  logic [7:0] d;
  pxr_sample_t sample;
  pxr_row_t rows [6];
  int miscompares;
  int samples_checked;
  int cycles;
  int runs;
  int mark;

  // pull-up wire: the device can only pull low
  assign sda = m_sda & ~o_sda_oe;

  pxr_host_model host (
    .i_clock(i_clock),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda(m_sda)
  );

  // short counts keep the run brief
  pxr_proximity_ranging_control #(
    .MEAS_LEN(20),
    .UNIT_LEN(10)
  ) uut (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_scl(scl),
    .i_sda(sda),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe),
    .i_gpio0_shutdown_n(pin_n),
    .i_sensor_sample(sample),
    .o_ranging_active(active)
  );

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic results();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [15:0] idx,
                      input logic [7:0] mask, input logic [7:0] exp,
                      input string what);
    host.rd(a, idx, d, ack);
    check(what, d & mask, exp);
  endtask

  // measurement starts counted on the rising edge of the active flag
  always @(posedge i_clock) begin
    cycles++;
    last_act <= active;
    if (active && !last_act)
      runs++;
    if (cycles == LIMIT) begin
      miscompares++;
      results();
    end
  end

  initial begin
    // reset falls after time zero so every flop is sure to see the edge
    i_reset_n = 1'b1;
    pin_n = 1'b1;
    sample = '0;
    #1 i_reset_n = 1'b0;
    @(posedge i_clock);
    #1;
    check("oe in reset", {7'h00, o_sda_oe}, 8'h00);
    check("active in reset", {7'h00, active}, 8'h00);
    @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    $display("test reset done");

    rows = '{'{IDX_POWERUP, 8'hFF, POWERUP_RESET},
      '{IDX_RANGE_STATUS, 8'h01, 8'h01},
      '{IDX_INT_STATUS, 8'h04, 8'h00},
      '{IDX_MEAS_PERIOD, 8'hFF, MEAS_PERIOD_RESET},
      '{IDX_TARGET_ADDR, 8'h7F, 8'h29},
      '{16'h0100, 8'hFF, 8'h00}};
    foreach (rows[i]) begin
      host.rd(A0, rows[i].idx, d, ack);
      check("addr ack", {7'h00, ack}, 8'h01);
      check("reset row", d & rows[i].mask, rows[i].exp);
    end
    $display("test table done");

    // flag hold, address move, then shutdown undoes both
    host.wr(A0, IDX_POWERUP, 8'h00, ack);
    rchk(A0, IDX_POWERUP, 8'hFF, 8'h00, "flag held");
    host.wr(A0, IDX_TARGET_ADDR, 8'h12, ack);
    rchk(7'h12, IDX_POWERUP, 8'hFF, 8'h00, "new addr");
    host.rd(A0, IDX_POWERUP, d, ack);
    check("old addr ack", {7'h00, ack}, 8'h00);
    pin_n <= 1'b0;
    host.rd(A0, IDX_POWERUP, d, ack);
    check("shutdown ack", {7'h00, ack}, 8'h00);
    pin_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    rchk(A0, IDX_POWERUP, 8'hFF, 8'h01, "fresh");
    host.wr(A0, IDX_MEAS_PERIOD, 8'h00, ack);
    $display("test shutdown done");

    sample <= '{error_code: 4'h3, distance_mm: 8'h5A};
    mark = runs;
    host.wr(A0, IDX_RANGE_START, START_SINGLE, ack);
    d = 8'h00;
    for (int k = 0; k < 8 && !d[2]; k++)
      host.rd(A0, IDX_INT_STATUS, d, ack);
    check("new sample", d & 8'h04, 8'h04);
    repeat (300) @(posedge i_clock);
    check("single runs", 8'(runs - mark), 8'h01);
    rchk(A0, IDX_RANGE_VALUE, 8'hFF, 8'h5A, "mm");
    rchk(A0, IDX_RANGE_STATUS, 8'hFF, 8'h31, "status");
    host.wr(A0, IDX_INT_CLEAR, 8'h07, ack);
    rchk(A0, IDX_INT_STATUS, 8'h04, 8'h00, "cleared");
    $display("test single done");

    sample <= '{error_code: 4'h0, distance_mm: 8'h21};
    mark = runs;
    host.wr(A0, IDX_RANGE_START, START_CONT, ack);
    rchk(A0, IDX_RANGE_STATUS, 8'h01, 8'h00, "busy");
    rchk(A0, IDX_RANGE_START, 8'h02, 8'h02, "cont flag");
    check("repeats", {7'h00, (runs - mark) > 4}, 8'h01);
    rchk(A0, IDX_INT_STATUS, 8'h04, 8'h04, "sticky");
    host.wr(A0, IDX_RANGE_START, START_SINGLE, ack);
    repeat (40) @(posedge i_clock);
    mark = runs;
    repeat (300) @(posedge i_clock);
    check("stopped", 8'(runs - mark), 8'h00);
    rchk(A0, IDX_RANGE_VALUE, 8'hFF, 8'h21, "cont mm");
    rchk(A0, IDX_RANGE_STATUS, 8'hFF, 8'h01, "idle");
    $display("test continuous done");
    results();
  end
endmodule
`default_nettype wire
